// File: hw/tec_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: Direction bit 0 drives pin, 1 releases
// R2: Reset sets direction register to all ones
// R3: Timer output needs direction and latch zero
// R4: Input pins work whatever the latch holds
// R5: Mode 11 starts counting on count clock
// R6: Match with compare zero clears, raises irq
// R7: Match interval is compare plus one
// R8: Compare zero must never be zero
// R9: Compare one match always raises irq one
// R10: Counter reads never disturb counting
// R11: Mode 00 stops and zeroes counter
// R12: Output control 03 toggles pin per match
// R13: Clock select 11 counts input zero edges
// R14: No edge counting in edge-clear mode
// R15: First match needs compare plus two edges
// R16: Edge accepted after two equal samples
// R17: Mode 10 input-zero edge clears counter
// R18: Without edges counter overflows, keeps going
// R19: Both registers compare or capture as configured
// R20: Edge select: fall, rise, both, one prohibited
// R21: Prescaler register rewritten only when stopped
// R22: Counter wraps from maximum to zero
module tec_timer
(
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  input  wire tec_pkg::tec_bus_req_type busReq,
  output logic [15:0]                   busRdata,
  input  wire logic [6:0]               portIn,
  output logic [6:0]                    portOut,
  output logic [6:0]                    portOeN,
  output logic                          matchIrqZero,
  output logic                          matchIrqOne
);
  // Software-visible registers
  logic [7:0]  portDirReg, portDirNext;     // port_zero_direction
  logic [7:0]  portLatchReg, portLatchNext; // Port output latch
  logic [7:0]  modeCtrlReg, modeCtrlNext;   // timer_mode_control
  logic [7:0]  prescaleReg, prescaleNext;   // prescaler_edge_select
  logic [7:0]  capCtrlReg, capCtrlNext;     // capcomp_control_reg
  logic [7:0]  outCtrlReg, outCtrlNext;     // output_control_reg
  logic [15:0] capZeroReg, capZeroNext;     // capcomp_reg_zero
  logic [15:0] capOneReg, capOneNext;       // capcomp_reg_one
  // Timer state
  logic [15:0] countReg, countNext;         // timer_count
  logic [7:0]  divReg, divNext;             // Free-running prescaler
  logic        timerOutReg, timerOutNext;   // timer_out_pin level
  logic        irqZeroReg, irqZeroNext;
  logic        irqOneReg, irqOneNext;
  logic [15:0] rdataReg, rdataNext;
  tec_pkg::tec_state_type stateReg, stateNext;
  // Decoded controls
  tec_pkg::tec_mode_type   mode;
  tec_pkg::tec_clksel_type clkSel;
  tec_pkg::tec_edge_type   edgeZero;        // ext_input_zero edges
  tec_pkg::tec_edge_type   edgeOne;         // ext_input_one edges
  logic tick, running, counting, matchZero, matchOne, edgeClear;
  logic zeroIsCapture, oneIsCapture, capZeroEvent, capOneEvent;

  // True once every 2**exp cycles of the prescaler
  function automatic logic divTap(input logic [7:0] div, input int exp);
    logic [7:0] mask;
    mask = 8'((9'h001 << exp) - 9'h001);
    return (div & mask) == mask;
  endfunction

  // Input zero filter; latch contents never block input use
  tec_edge_filter filterZero
  (
    .clock   (clock),
    .reset_n (reset_n),
    .pinLevel(portIn[0]), // R4
    .edgeSel (prescaleReg[tec_pkg::PRM_ES0_LSB +: 2]),
    .edgeOut (edgeZero)
  );

  // Input one shares the timer pin
  tec_edge_filter filterOne
  (
    .clock   (clock),
    .reset_n (reset_n),
    .pinLevel(portIn[tec_pkg::TIMER_PIN]),
    .edgeSel (prescaleReg[tec_pkg::PRM_ES1_LSB +: 2]),
    .edgeOut (edgeOne)
  );

  // Field decode and count clock selection
  always_comb
  begin
    mode = tec_pkg::tec_mode_type'(modeCtrlReg[tec_pkg::MODE_LSB +: 2]);
    clkSel = tec_pkg::tec_clksel_type'(prescaleReg[tec_pkg::PRM_CLK_LSB +: 2]);
    case (clkSel)
      tec_pkg::CLK_DIRECT:   tick = 1'b1;
      tec_pkg::CLK_DIV_A:    tick = divTap(divReg, tec_pkg::DIV_A_EXP);
      tec_pkg::CLK_DIV_B:    tick = divTap(divReg, tec_pkg::DIV_B_EXP);
      default:               tick = edgeZero.valid; // R13
    endcase
    running = (mode != tec_pkg::MODE_STOP);
    counting = running && tick && (stateReg == tec_pkg::ST_RUN);
    zeroIsCapture = capCtrlReg[tec_pkg::CRC_ZERO_CAPTURE];
    oneIsCapture = capCtrlReg[tec_pkg::CRC_ONE_CAPTURE];
    // Compares fire on the count clock while the value stands
    matchZero = counting && !zeroIsCapture && (countReg == capZeroReg);
    matchOne = counting && !oneIsCapture && (countReg == capOneReg); // R9
    // Software may not pair this with edge counting; if it does, clear wins
    edgeClear = (mode == tec_pkg::MODE_EDGE_CLEAR) && edgeZero.valid; // R14
    capOneEvent = edgeClear && oneIsCapture; // R19
    capZeroEvent = (mode == tec_pkg::MODE_EDGE_CLEAR) && zeroIsCapture
      && (capCtrlReg[tec_pkg::CRC_ZERO_REVERSE] ? edgeZero.reverse : edgeOne.valid);
  end

  // Next values of registers, counter and outputs
  always_comb
  begin
    portDirNext = portDirReg;
    portLatchNext = portLatchReg;
    modeCtrlNext = modeCtrlReg;
    prescaleNext = prescaleReg;
    capCtrlNext = capCtrlReg;
    outCtrlNext = outCtrlReg;
    capZeroNext = capZeroReg;
    capOneNext = capOneReg;
    timerOutNext = timerOutReg;
    divNext = divReg + 8'h01;
    rdataNext = tec_pkg::WORD_RESET;

    // Sequencer: first count clock after start only arms the count
    case (stateReg)
      tec_pkg::ST_IDLE:  stateNext = running ? tec_pkg::ST_ARMED : tec_pkg::ST_IDLE; // R5
      tec_pkg::ST_ARMED: stateNext = !running ? tec_pkg::ST_IDLE
                                   : (tick ? tec_pkg::ST_RUN : tec_pkg::ST_ARMED); // R15
      tec_pkg::ST_RUN:   stateNext = running ? tec_pkg::ST_RUN : tec_pkg::ST_IDLE;
      default:           stateNext = tec_pkg::ST_IDLE;
    endcase

    // Counter
    if (!running)
      countNext = tec_pkg::WORD_RESET; // R11
    else if (edgeClear)
      countNext = tec_pkg::WORD_RESET; // R17
    else if (matchZero && (mode == tec_pkg::MODE_MATCH_CLEAR))
      countNext = tec_pkg::WORD_RESET; // R6 R7
    else if (counting)
      countNext = countReg + 16'h0001; // R18 R22
    else
      countNext = countReg;

    // Timer output toggles
    if (outCtrlReg[tec_pkg::TOC_ENABLE])
    begin
      if ((matchZero && outCtrlReg[tec_pkg::TOC_MATCH0_TOG]) // R12
          ^ (matchOne && outCtrlReg[tec_pkg::TOC_MATCH1_TOG])
          ^ (edgeClear && modeCtrlReg[tec_pkg::TMC_EDGE_TOGGLE]))
        timerOutNext = !timerOutReg;
    end

    // Interrupt requests, one cycle each
    irqZeroNext = matchZero || (capZeroEvent && !capCtrlReg[tec_pkg::CRC_ZERO_REVERSE]);
    irqOneNext = matchOne || capOneEvent; // R9

    // Register writes
    if (busReq.write)
    begin
      case (busReq.addr)
        tec_pkg::ADDR_PORT_DIR:     portDirNext = busReq.wdata[7:0] | 8'h80;
        tec_pkg::ADDR_PORT_LATCH:   portLatchNext = busReq.wdata[7:0];
        tec_pkg::ADDR_MODE_CTRL:    modeCtrlNext = busReq.wdata[7:0];
        tec_pkg::ADDR_PRESCALE:     prescaleNext = busReq.wdata[7:0] & 8'hf3; // R21
        tec_pkg::ADDR_CAPCOMP_CTRL: capCtrlNext = busReq.wdata[7:0] & 8'h07;
        tec_pkg::ADDR_CAPCOMP_ZERO: capZeroNext = busReq.wdata; // R8
        tec_pkg::ADDR_CAPCOMP_ONE:  capOneNext = busReq.wdata;
        tec_pkg::ADDR_OUT_CTRL:
        begin
          // Level set and reset are one-shot and read back as zero
          outCtrlNext = busReq.wdata[7:0] & 8'h13;
          if (busReq.wdata[tec_pkg::TOC_LEVEL_SET])
            timerOutNext = 1'b1;
          else if (busReq.wdata[tec_pkg::TOC_LEVEL_RESET])
            timerOutNext = 1'b0;
        end
        default:                    portLatchNext = portLatchReg;
      endcase
    end

    // Captures and overflow flag after writes, so hardware events win
    if (capZeroEvent)
      capZeroNext = countReg; // R19
    if (capOneEvent)
      capOneNext = countReg;
    if (counting && (countReg == tec_pkg::COUNT_MAX))
      modeCtrlNext[tec_pkg::TMC_OVERFLOW] = 1'b1; // R18

    // Register reads are side-effect free
    if (busReq.read)
    begin
      case (busReq.addr)
        tec_pkg::ADDR_PORT_DIR:     rdataNext = {8'h00, portDirReg};
        tec_pkg::ADDR_PORT_LATCH:   rdataNext = {8'h00, portLatchReg};
        tec_pkg::ADDR_MODE_CTRL:    rdataNext = {8'h00, modeCtrlReg};
        tec_pkg::ADDR_PRESCALE:     rdataNext = {8'h00, prescaleReg};
        tec_pkg::ADDR_CAPCOMP_CTRL: rdataNext = {8'h00, capCtrlReg};
        tec_pkg::ADDR_OUT_CTRL:     rdataNext = {8'h00, outCtrlReg};
        tec_pkg::ADDR_CAPCOMP_ZERO: rdataNext = capZeroReg;
        tec_pkg::ADDR_CAPCOMP_ONE:  rdataNext = capOneReg;
        tec_pkg::ADDR_COUNT:        rdataNext = countReg; // R10
        default:                    rdataNext = tec_pkg::WORD_RESET;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      portDirReg <= tec_pkg::DIR_RESET; // R2
      portLatchReg <= tec_pkg::BYTE_RESET;
      modeCtrlReg <= tec_pkg::BYTE_RESET;
      prescaleReg <= tec_pkg::BYTE_RESET;
      capCtrlReg <= tec_pkg::BYTE_RESET;
      outCtrlReg <= tec_pkg::BYTE_RESET;
      capZeroReg <= tec_pkg::WORD_RESET;
      capOneReg <= tec_pkg::WORD_RESET;
      countReg <= tec_pkg::WORD_RESET;
      divReg <= tec_pkg::BYTE_RESET;
      timerOutReg <= 1'b0;
      irqZeroReg <= 1'b0;
      irqOneReg <= 1'b0;
      rdataReg <= tec_pkg::WORD_RESET;
      stateReg <= tec_pkg::ST_IDLE;
    end
    else
    begin
      portDirReg <= portDirNext;
      portLatchReg <= portLatchNext;
      modeCtrlReg <= modeCtrlNext;
      prescaleReg <= prescaleNext;
      capCtrlReg <= capCtrlNext;
      outCtrlReg <= outCtrlNext;
      capZeroReg <= capZeroNext;
      capOneReg <= capOneNext;
      countReg <= countNext;
      divReg <= divNext;
      timerOutReg <= timerOutNext;
      irqZeroReg <= irqZeroNext;
      irqOneReg <= irqOneNext;
      rdataReg <= rdataNext;
      stateReg <= stateNext;
    end
  end

  // Pins: timer level is ORed into latch, so latch must be zero to see it
  always_comb
  begin
    portOeN = portDirReg[6:0]; // R1
    portOut = portLatchReg[6:0];
    portOut[tec_pkg::TIMER_PIN] = portLatchReg[tec_pkg::TIMER_PIN] | timerOutReg; // R3
  end

  assign busRdata = rdataReg;
  assign matchIrqZero = irqZeroReg;
  assign matchIrqOne = irqOneReg;

  // Checks
  a_dir_reset: assert property (@(posedge clock) // R2
    !reset_n |=> portDirReg == 8'hff && portOeN == 7'h7f)
    else $error("direction register not all ones after reset");
  // A written direction bit must reach the buffer enable on the next cycle
  a_pin_buffer: assert property (@(posedge clock) disable iff (!reset_n) // R1
    (busReq.write && busReq.addr == tec_pkg::ADDR_PORT_DIR)
    |=> portOeN == $past(busReq.wdata[6:0]))
    else $error("pin buffer enable disagrees with written direction");
  a_mode_start: assert property (@(posedge clock) disable iff (!reset_n) // R5
    (stateReg == tec_pkg::ST_IDLE && mode == tec_pkg::MODE_MATCH_CLEAR)
    |=> stateReg == tec_pkg::ST_ARMED)
    else $error("count did not arm on start");
  a_first_tick: assert property (@(posedge clock) disable iff (!reset_n) // R15
    (stateReg == tec_pkg::ST_ARMED && running && tick && !edgeClear)
    |=> stateReg == tec_pkg::ST_RUN && countReg == 16'h0000)
    else $error("first count clock advanced the counter");
  a_match_clear: assert property (@(posedge clock) disable iff (!reset_n) // R6
    (matchZero && mode == tec_pkg::MODE_MATCH_CLEAR && !edgeClear)
    |=> countReg == 16'h0000 && matchIrqZero)
    else $error("match did not clear counter and raise request");
  a_match_one: assert property (@(posedge clock) disable iff (!reset_n) // R9
    (counting && !oneIsCapture && countReg == capOneReg) |=> matchIrqOne)
    else $error("compare one match gave no request");
  a_stop_init: assert property (@(posedge clock) disable iff (!reset_n) // R11
    (mode == tec_pkg::MODE_STOP) |=> countReg == 16'h0000 && !matchIrqZero)
    else $error("stopped counter not zero");
  a_square_wave: assert property (@(posedge clock) disable iff (!reset_n) // R12
    (matchZero && outCtrlReg == 8'h03 && !busReq.write && !matchOne)
    |=> timerOutReg != $past(timerOutReg))
    else $error("timer output did not toggle on match");
  a_edge_count: assert property (@(posedge clock) disable iff (!reset_n) // R13
    (counting && clkSel == tec_pkg::CLK_EXT_EDGE && !matchZero && !edgeClear)
    |=> countReg == $past(countReg) + 16'h0001)
    else $error("valid edge did not advance counter");
  a_edge_clear: assert property (@(posedge clock) disable iff (!reset_n) // R17
    (running && edgeClear) |=> countReg == 16'h0000)
    else $error("input zero edge did not clear counter");
  a_count_wrap: assert property (@(posedge clock) disable iff (!reset_n) // R18 R22
    (counting && countReg == 16'hffff && !edgeClear && !matchZero)
    |=> countReg == 16'h0000 && stateReg == tec_pkg::ST_RUN)
    else $error("counter did not wrap and keep running");
  a_count_read: assert property (@(posedge clock) disable iff (!reset_n) // R10
    (busReq.read && busReq.addr == tec_pkg::ADDR_COUNT)
    |=> busRdata == $past(countReg))
    else $error("counter read returned wrong value");
endmodule
`default_nettype wire

// File: hw/tec_pkg.sv
`default_nettype none
package tec_pkg;
  // Register addresses on the memory-manipulation port
  localparam logic [15:0] ADDR_PORT_LATCH   = 16'hff00;
  localparam logic [15:0] ADDR_PORT_DIR     = 16'hff20;
  localparam logic [15:0] ADDR_COUNT        = 16'hff10;
  localparam logic [15:0] ADDR_CAPCOMP_ZERO = 16'hff12;
  localparam logic [15:0] ADDR_CAPCOMP_ONE  = 16'hff14;
  localparam logic [15:0] ADDR_MODE_CTRL    = 16'hffba;
  localparam logic [15:0] ADDR_PRESCALE     = 16'hffbb;
  localparam logic [15:0] ADDR_CAPCOMP_CTRL = 16'hffbc;
  localparam logic [15:0] ADDR_OUT_CTRL     = 16'hffbd;

  // Values after reset, and the counter maximum
  localparam logic [7:0]  DIR_RESET   = 8'hff;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // Field positions
  localparam int MODE_LSB         = 2;
  localparam int TMC_EDGE_TOGGLE  = 1;
  localparam int TMC_OVERFLOW     = 0;
  localparam int PRM_CLK_LSB      = 0;
  localparam int PRM_ES0_LSB      = 4;
  localparam int PRM_ES1_LSB      = 6;
  localparam int TOC_ENABLE       = 0;
  localparam int TOC_MATCH0_TOG   = 1;
  localparam int TOC_LEVEL_RESET  = 2;
  localparam int TOC_LEVEL_SET    = 3;
  localparam int TOC_MATCH1_TOG   = 4;
  localparam int CRC_ZERO_CAPTURE = 0;
  localparam int CRC_ZERO_REVERSE = 1;
  localparam int CRC_ONE_CAPTURE  = 2;
  localparam int TIMER_PIN        = 1;

  // Prescaler width, and taps as powers of two
  localparam int PRESCALE_WIDTH = 8;
  localparam int DIV_A_EXP      = 2;
  localparam int DIV_B_EXP      = 8;

  // Operating mode field
  typedef enum logic [1:0] {
    MODE_STOP        = 2'b00,
    MODE_FREE        = 2'b01,
    MODE_EDGE_CLEAR  = 2'b10,
    MODE_MATCH_CLEAR = 2'b11
  } tec_mode_type;

  // Count clock select field
  typedef enum logic [1:0] {
    CLK_DIRECT   = 2'b00,
    CLK_DIV_A    = 2'b01,
    CLK_DIV_B    = 2'b10,
    CLK_EXT_EDGE = 2'b11
  } tec_clksel_type;

  // Valid edge select field
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } tec_edgesel_type;

  // Counter sequencing, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN   = 3'b100
  } tec_state_type;

  // Filtered edge report
  typedef struct packed {
    logic valid;
    logic reverse;
  } tec_edge_type;

  // Register access request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
  } tec_bus_req_type;
endpackage
`default_nettype wire

// File: hw/tec_edge_filter.sv
`timescale 1ns/10ps
`default_nettype none
module tec_edge_filter
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  pinLevel,
  input  wire logic [1:0]            edgeSel,
  output var  tec_pkg::tec_edge_type edgeOut
);
  logic                  sampleReg;    // Previous sample
  logic                  levelReg;     // Accepted level
  tec_pkg::tec_edge_type edgeReg;      // Registered report
  logic                  levelNext;
  tec_pkg::tec_edge_type edgeNext;
  logic                  accept;
  logic                  rise;
  logic                  fall;

  // New level must show on two samples in a row, so short spikes die here
  always_comb
  begin
    accept = (pinLevel == sampleReg) && (sampleReg != levelReg); // R16
    levelNext = accept ? sampleReg : levelReg;
    rise = accept && sampleReg;
    fall = accept && !sampleReg;
    edgeNext = '0;
    case (tec_pkg::tec_edgesel_type'(edgeSel)) // R20
      tec_pkg::EDGE_FALL:
      begin
        edgeNext.valid = fall;
        edgeNext.reverse = rise;
      end
      tec_pkg::EDGE_RISE:
      begin
        edgeNext.valid = rise;
        edgeNext.reverse = fall;
      end
      tec_pkg::EDGE_BOTH:
      begin
        edgeNext.valid = accept;
      end
      default:
      begin
        // Prohibited code: no edge is ever reported
        edgeNext = '0;
      end
    endcase
  end

  // Sample and report registers
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      sampleReg <= 1'b0;
      levelReg <= 1'b0;
      edgeReg <= '0;
    end
    else
    begin
      sampleReg <= pinLevel;
      levelReg <= levelNext;
      edgeReg <= edgeNext;
    end
  end

  assign edgeOut = edgeReg;
endmodule
`default_nettype wire

// File: test/tec_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// Outside world on port zero: pulse source on input zero, load on the timer pin
module tec_pin_model
(
  input  wire logic [6:0] portOut,
  input  wire logic [6:0] portOeN,
  input  wire logic       clock,
  output logic [6:0]      portIn,
  output var int          toggleCount
);
  logic       srcLevel; // Level driven on input zero
  logic [4:0] noise;    // Unused pins have no pulls, so they wander
  logic       lastOut;  // Last timer pin level seen by the load

  initial
  begin
    srcLevel = 1'b0;
    noise = 5'h00;
    lastOut = 1'b0;
    toggleCount = 0;
  end

  // Pin one shows the device level only while driven, else a changing value
  assign portIn = {noise, (portOeN[1] == 1'b0) ? portOut[1] : noise[0], srcLevel};

  // Floating pins follow a counter stepped every cycle so a stale value never looks valid
  always @(negedge clock)
    noise <= noise + 5'h01;

  // Load counts level changes of the driven timer pin
  always @(posedge clock)
  begin
    if (portOeN[1] == 1'b0)
    begin
      if (portOut[1] !== lastOut)
        toggleCount <= toggleCount + 1;
      lastOut <= portOut[1];
    end
  end

  // Source holds a level for whole cycles, changed only at falling edges
  task automatic hold(input logic level, input int cycles);
    srcLevel = level;
    repeat (cycles) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// File: test/timer_event_counter_modes_test.sv
`timescale 1ns/10ps
`default_nettype none
module timer_event_counter_modes_test;
  logic                     clock;        // 125 MHz clock
  logic                     reset_n;      // Synchronous reset, active low
  tec_pkg::tec_bus_req_type busReq;       // Register request
  logic [15:0]              busRdata;     // Register read data
  logic [6:0]               portIn;       // Pin levels seen by the device
  logic [6:0]               portOut;      // Pin output values
  logic [6:0]               portOeN;      // Output enables, low drives
  logic                     matchIrqZero; // Compare zero request
  logic                     matchIrqOne;  // Compare one request
  int                       toggleCount;  // Timer pin changes seen by the load
  int                       mismatches;   // Failed comparisons
  int                       tests_run;    // All comparisons
  int                       cycleNo;      // Rising edges since start
  int                       irqOneCount;  // Compare one pulses
  int                       irqZeroAt[$]; // Cycle of each compare zero pulse

  tec_timer u_tec_timer
  (
    .clock        (clock),
    .reset_n      (reset_n),
    .busReq       (busReq),
    .busRdata     (busRdata),
    .portIn       (portIn),
    .portOut      (portOut),
    .portOeN      (portOeN),
    .matchIrqZero (matchIrqZero),
    .matchIrqOne  (matchIrqOne)
  );

  tec_pin_model u_tec_pin_model
  (
    .portOut     (portOut),
    .portOeN     (portOeN),
    .clock       (clock),
    .portIn      (portIn),
    .toggleCount (toggleCount)
  );

  // Free-running clock
  always #4 clock = ~clock;

  // Cycle count and request monitors, sampled where outputs are settled
  always @(posedge clock)
    cycleNo <= cycleNo + 1;
  always @(negedge clock)
  begin
    if (matchIrqZero === 1'b1)
      irqZeroAt.push_back(cycleNo);
    if (matchIrqOne === 1'b1)
      irqOneCount++;
  end

  // One comparison, counted and reported on mismatch
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expected);
    tests_run++;
    if (seen !== expected)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, expected, seen);
    end
  endtask

  // Write pulse for one cycle, raised at the next falling edge and dropped at the one after
  task automatic busWrite(input logic [15:0] addr, input logic [15:0] data);
    @(negedge clock);
    busReq = '{addr: addr, wdata: data, write: 1'b1, read: 1'b0};
    @(negedge clock);
    busReq.write = 1'b0;
  endtask

  // Read data is registered on the taking edge and sampled half a cycle later
  task automatic busRead(input logic [15:0] addr, output logic [15:0] data);
    @(negedge clock);
    busReq = '{addr: addr, wdata: 16'h0000, write: 1'b0, read: 1'b1};
    @(negedge clock);
    busReq.read = 1'b0;
    data = busRdata;
  endtask

  task automatic readCheck(input string name, input logic [15:0] addr, input logic [15:0] exp);
    logic [15:0] data;
    busRead(addr, data);
    check(name, data, exp);
  endtask

  // Reset values, then direction and latch set-up for the timer pin
  task automatic pinScenario();
    check("oe after reset", {9'h000, portOeN}, 16'h007f);
    readCheck("dir after reset", tec_pkg::ADDR_PORT_DIR, 16'h00ff);
    readCheck("unmapped read", 16'hff30, 16'h0000);
    busWrite(tec_pkg::ADDR_PORT_DIR, 16'h007d);
    busWrite(tec_pkg::ADDR_PORT_LATCH, 16'h0001);
    check("oe follows dir", {9'h000, portOeN}, 16'h007d);
    readCheck("dir readback", tec_pkg::ADDR_PORT_DIR, 16'h00fd);
    check("timer pin idle", {15'h0000, portOut[1]}, 16'h0000);
  endtask

  // Interval with square wave, counter reads in flight, then stop
  task automatic intervalScenario();
    int          w;
    int          n;
    int          t0;
    logic [15:0] cnt;
    t0 = toggleCount;
    irqZeroAt.delete();
    irqOneCount = 0;
    busWrite(tec_pkg::ADDR_CAPCOMP_ZERO, 16'h0002);
    busWrite(tec_pkg::ADDR_CAPCOMP_ONE, 16'h0001);
    busWrite(tec_pkg::ADDR_OUT_CTRL, 16'h0003);
    busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h000c);
    w = cycleNo;
    repeat (6)
    begin
      busRead(tec_pkg::ADDR_COUNT, cnt);
      check("count in range", {15'h0000, cnt <= 16'h0002}, 16'h0001);
    end
    repeat (8) @(negedge clock);
    busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h0000);
    repeat (3) @(negedge clock);
    n = irqZeroAt.size();
    check("irq count", {15'h0000, n >= 5}, 16'h0001);
    check("first irq", 16'(irqZeroAt[0] - w), 16'h0005);
    for (int k = 1; k < n; k++)
      check("irq gap", 16'(irqZeroAt[k] - irqZeroAt[k - 1]), 16'h0003);
    check("pin toggles", 16'(toggleCount - t0), 16'(n));
    check("irq one", {15'h0000, irqOneCount == n || irqOneCount == n + 1}, 16'h0001);
    readCheck("stopped count", tec_pkg::ADDR_COUNT, 16'h0000);
    repeat (10) @(negedge clock);
    check("no irq stopped", 16'(irqZeroAt.size()), 16'(n));
  endtask

  // Event counting for every edge code, with short glitches between pulses
  task automatic eventScenario();
    logic [15:0] exp [4];
    exp = '{16'h0001, 16'h0001, 16'h0000, 16'h0002};
    for (int c = 0; c < 4; c++)
    begin
      busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h0000);
      busWrite(tec_pkg::ADDR_PRESCALE, {8'h00, 2'b00, 2'(c), 4'h3});
      busWrite(tec_pkg::ADDR_CAPCOMP_ZERO, 16'h0001);
      busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h000c);
      irqZeroAt.delete();
      repeat (3)
      begin
        u_tec_pin_model.hold(1'b1, 1);
        u_tec_pin_model.hold(1'b0, 7);
        u_tec_pin_model.hold(1'b1, 6);
        u_tec_pin_model.hold(1'b0, 8);
      end
      check("event irqs", 16'(irqZeroAt.size()), exp[c]);
    end
    busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h0000);
  endtask

  // Divided count clock: a compare value of one gives two ticks of four cycles
  task automatic divScenario();
    int n;
    busWrite(tec_pkg::ADDR_PRESCALE, 16'h0001);
    busWrite(tec_pkg::ADDR_CAPCOMP_ZERO, 16'h0001);
    irqZeroAt.delete();
    busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h000c);
    repeat (40) @(negedge clock);
    busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h0000);
    n = irqZeroAt.size();
    check("div irq count", {15'h0000, n >= 3}, 16'h0001);
    for (int k = 1; k < n; k++)
      check("div irq gap", 16'(irqZeroAt[k] - irqZeroAt[k - 1]), 16'h0008);
  endtask

  // Edge clear with capture into register one, then a full wrap with no edge
  task automatic edgeClearScenario();
    logic [15:0] a;
    logic [15:0] b;
    int          i1;
    i1 = irqOneCount;
    busWrite(tec_pkg::ADDR_PRESCALE, 16'h0010);
    busWrite(tec_pkg::ADDR_CAPCOMP_ZERO, 16'hffff);
    busWrite(tec_pkg::ADDR_CAPCOMP_CTRL, 16'h0004);
    busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h0008);
    u_tec_pin_model.hold(1'b0, 40);
    u_tec_pin_model.hold(1'b1, 6);
    busRead(tec_pkg::ADDR_COUNT, a);
    check("edge cleared", {15'h0000, a < 16'h000a}, 16'h0001);
    // Edge lands after forty counts, so register one holds forty
    readCheck("capture one", tec_pkg::ADDR_CAPCOMP_ONE, 16'h0028);
    check("capture irq", 16'(irqOneCount - i1), 16'h0001);
    // Reads 65536 edges apart see the same value only if the count wrapped
    busRead(tec_pkg::ADDR_COUNT, a);
    repeat (65534) @(negedge clock);
    busRead(tec_pkg::ADDR_COUNT, b);
    check("wrapped count", b, a);
    readCheck("overflow flag", tec_pkg::ADDR_MODE_CTRL, 16'h0009);
    busWrite(tec_pkg::ADDR_MODE_CTRL, 16'h0000);
    u_tec_pin_model.hold(1'b0, 2);
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    busReq = '0;
    mismatches = 0;
    tests_run = 0;
    cycleNo = 0;
    irqOneCount = 0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    pinScenario();
    intervalScenario();
    eventScenario();
    divScenario();
    edgeClearScenario();
    final_report();
  end

  // Watchdog: the wrap wait dominates, about 66000 cycles in all
  initial
  begin
    repeat (90000) @(posedge clock);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
